// file: logic/wdc_pkg.sv
package wdc_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h01;
    localparam logic [7:0] EVT_OFS = 8'h02;
    localparam logic [7:0] MASK_OFS = 8'h03;

    localparam int WIN_LSB = 4;
    localparam int PER_LSB = 0;
    localparam int LOCK_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    localparam int EVT_TIMEOUT = 0;
    localparam int EVT_EARLY = 1;
    localparam int EVT_SYNCED = 2;

    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] SEL_MAX = 4'hb;
    localparam logic [13:0] BASE_TICKS = 14'h0008;
    localparam int CNT_W = 14;

    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_HZ = 1024;
    localparam int TICK_DIV_CYC = CLK_HZ / TICK_HZ;
    localparam int SYNC_TICKS = 2;
    localparam logic [2:0] GUARD_WIN_CYC = 3'h4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdc_bus_type;

    typedef enum logic [1:0] {WDC_OFF, WDC_OPEN, WDC_CLOSED} wdc_state_type;
    typedef enum logic {WDC_BOOT, WDC_RUN} wdc_boot_type;
endpackage

// file: logic/wdc_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module wdc_tick_div #(
    parameter int DIV = wdc_pkg::TICK_DIV_CYC
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    // one-cycle enable standing in for the slow tick clock
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r >= 32'(DIV - 1)) begin
            cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// file: logic/wdc_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R1] control: closed-window select in bits 7:4, timeout select in bits 3:0
// [R2] nonzero window code enables window mode; codes 1..11 give 8..8192 ticks closed
// [R3] nonzero timeout code enables watchdog; codes 1..11 give 8..8192 ticks
// [R4] in window mode the timeout code sets the open window length
// [R5] freeze bit set makes both control fields read-only
// [R6] software may set the freeze bit (status bit 7); zero leaves it outside debug mode
// [R7] freeze bit clears only while debug mode is active
// [R8] nonzero timeout code after boot load sets the freeze bit
// [R9] freeze bit writes need the change-guard unlock
// [R10] control write sets crossing pending (status bit 0) during transfer
// [R11] crossing pending clears when transfer into tick domain completes
// [R12] crossing pending is not under change-guard
// [R13] status register at 0x01 resets to zero
// [R14] control register is loaded from the boot config fuse
// [R15] missing kick before timeout issues a system reset
// [R16] kick in closed window resets at once; open follows closed
// [R17] counters advance on the slow tick of about 1.024 kHz
// [R18] control writes only accepted shortly after a change-guard unlock
// [R19] select codes above 0xB behave as the longest duration
module wdc_top #(
    parameter int TICK_DIV = wdc_pkg::TICK_DIV_CYC
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [7:0] RDATA,
    input wire logic [7:0] FUSE_CFG,
    input wire logic FUSE_DONE,
    input wire logic GUARD_UNLOCK,
    input wire logic DEBUG_MODE,
    input wire logic KICK,
    output logic SYS_RESET_REQ,
    output logic IRQ
);
    wdc_pkg::wdc_bus_type bus;
    logic tick;
    logic xfer_start;
    logic busy;
    logic xfer_done;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR_EN, rd: RD_EN};

    function automatic logic [13:0] sel_ticks(input logic [3:0] code);
        logic [3:0] c;
        c = (code > wdc_pkg::SEL_MAX) ? wdc_pkg::SEL_MAX : code; // R19
        if (c == wdc_pkg::SEL_OFF) begin
            sel_ticks = wdc_pkg::BASE_TICKS;
        end else begin
            sel_ticks = wdc_pkg::BASE_TICKS << (c - 4'h1); // R2 R3
        end
    endfunction

    wdc_tick_div #(.DIV(TICK_DIV)) u_div (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .tick(tick) // R17
    );

    wdc_xfer #(.TICKS(wdc_pkg::SYNC_TICKS)) u_xfer (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .start(xfer_start),
        .tick(tick),
        .busy(busy),
        .done(xfer_done)
    );

    // ---- configuration registers ----
    wdc_pkg::wdc_boot_type boot_r, boot_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] act_r, act_nxt;
    logic lock_r, lock_nxt;
    logic [2:0] guard_r, guard_nxt;
    logic guard_open;
    logic boot_load;
    logic wr_ctrl;
    logic wr_stat;

    assign guard_open = (guard_r != 3'h0);
    assign boot_load = (boot_r == wdc_pkg::WDC_BOOT) && FUSE_DONE;
    assign wr_ctrl = bus.wr && (bus.addr == wdc_pkg::CTRL_OFS);
    assign wr_stat = bus.wr && (bus.addr == wdc_pkg::STAT_OFS);
    // writes during an ongoing transfer are dropped
    assign xfer_start = wr_ctrl && guard_open && !lock_r && !busy; // R10 R12 R18

    always_comb begin
        boot_nxt = boot_r;
        ctrl_nxt = ctrl_r;
        act_nxt = act_r;
        lock_nxt = lock_r;
        guard_nxt = (guard_r != 3'h0) ? guard_r - 3'h1 : 3'h0;
        if (GUARD_UNLOCK) begin
            guard_nxt = wdc_pkg::GUARD_WIN_CYC; // R18
        end
        if (boot_load) begin
            boot_nxt = wdc_pkg::WDC_RUN;
            ctrl_nxt = FUSE_CFG; // R14
            act_nxt = FUSE_CFG;
            lock_nxt = (FUSE_CFG[wdc_pkg::PER_LSB +: 4] != wdc_pkg::SEL_OFF); // R8
        end else begin
            if (xfer_start) begin
                ctrl_nxt = bus.wdata; // R1 R5
            end
            if (xfer_done) begin
                act_nxt = ctrl_r; // R11
            end
            if (wr_stat && guard_open) begin // R9
                if (bus.wdata[wdc_pkg::LOCK_BIT]) begin
                    lock_nxt = 1'b1; // R6
                end else if (DEBUG_MODE) begin
                    lock_nxt = 1'b0; // R7
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            boot_r <= wdc_pkg::WDC_BOOT;
            ctrl_r <= wdc_pkg::CTRL_RST;
            act_r <= wdc_pkg::CTRL_RST;
            lock_r <= 1'b0; // R13
            guard_r <= 3'h0;
        end else begin
            boot_r <= boot_nxt;
            ctrl_r <= ctrl_nxt;
            act_r <= act_nxt;
            lock_r <= lock_nxt;
            guard_r <= guard_nxt;
        end
    end

    // ---- watchdog counter, runs on the applied copy ----
    wdc_pkg::wdc_state_type st_r, st_nxt;
    logic [13:0] cnt_r, cnt_nxt;
    logic kick_r, kick_nxt;
    logic rst_nxt;
    logic early_ev;
    logic tmo_ev;
    logic [3:0] per_sel;
    logic [3:0] win_sel;
    logic [13:0] cnt_inc;
    logic [13:0] lim;

    assign per_sel = act_r[wdc_pkg::PER_LSB +: 4];
    assign win_sel = act_r[wdc_pkg::WIN_LSB +: 4];
    assign cnt_inc = cnt_r + 14'h1;
    // R4: the open window and the normal timeout share the timeout code
    assign lim = (st_r == wdc_pkg::WDC_CLOSED) ? sel_ticks(win_sel) : sel_ticks(per_sel);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        kick_nxt = kick_r || KICK;
        rst_nxt = 1'b0;
        early_ev = 1'b0;
        tmo_ev = 1'b0;
        if (per_sel == wdc_pkg::SEL_OFF || boot_r == wdc_pkg::WDC_BOOT) begin
            st_nxt = wdc_pkg::WDC_OFF; // R3
            cnt_nxt = 14'h0;
            kick_nxt = 1'b0;
        end else if (DEBUG_MODE || xfer_done || st_r == wdc_pkg::WDC_OFF) begin
            // restart with a plain timeout; window starts at the first kick
            st_nxt = wdc_pkg::WDC_OPEN;
            cnt_nxt = 14'h0;
            kick_nxt = 1'b0;
        end else if (tick) begin // R17
            kick_nxt = KICK;
            cnt_nxt = cnt_inc;
            if (kick_r && st_r == wdc_pkg::WDC_CLOSED) begin
                rst_nxt = 1'b1; // R16
                early_ev = 1'b1;
                st_nxt = wdc_pkg::WDC_OPEN;
                cnt_nxt = 14'h0;
            end else if (kick_r) begin
                cnt_nxt = 14'h0;
                st_nxt = (win_sel != wdc_pkg::SEL_OFF) ? wdc_pkg::WDC_CLOSED
                                                       : wdc_pkg::WDC_OPEN; // R2
            end else if (cnt_inc >= lim) begin
                cnt_nxt = 14'h0;
                if (st_r == wdc_pkg::WDC_CLOSED) begin
                    st_nxt = wdc_pkg::WDC_OPEN; // R16
                end else begin
                    rst_nxt = 1'b1; // R15
                    tmo_ev = 1'b1;
                    st_nxt = wdc_pkg::WDC_OPEN;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            st_r <= wdc_pkg::WDC_OFF;
            cnt_r <= 14'h0;
            kick_r <= 1'b0;
            SYS_RESET_REQ <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            kick_r <= kick_nxt;
            SYS_RESET_REQ <= rst_nxt;
        end
    end

    // ---- event status, mask, interrupt and read port ----
    logic [2:0] evt_r, evt_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic [2:0] evt_set;
    logic irq_nxt;
    logic [7:0] rd_nxt;

    assign evt_set = {xfer_done, early_ev, tmo_ev};

    always_comb begin
        mask_nxt = mask_r;
        evt_nxt = evt_r;
        if (bus.rd && bus.addr == wdc_pkg::EVT_OFS) begin
            evt_nxt = 3'h0;
        end
        evt_nxt = evt_nxt | evt_set;
        if (bus.wr && bus.addr == wdc_pkg::MASK_OFS) begin
            mask_nxt = bus.wdata[2:0];
        end
        irq_nxt = |(evt_nxt & mask_nxt);
        rd_nxt = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                wdc_pkg::CTRL_OFS: rd_nxt = ctrl_r;
                wdc_pkg::STAT_OFS: rd_nxt = {lock_r, 6'h00, busy}; // R10 R11
                wdc_pkg::EVT_OFS: rd_nxt = {5'h00, evt_r};
                wdc_pkg::MASK_OFS: rd_nxt = {5'h00, mask_r};
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            evt_r <= wdc_pkg::EVT_RST;
            mask_r <= wdc_pkg::MASK_RST;
            IRQ <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
            IRQ <= irq_nxt;
            RDATA <= rd_nxt;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    lock_sticky_a: assert property (lock_r && !DEBUG_MODE |=> lock_r) // R7
        else $error("freeze bit cleared outside debug mode");
    ctrl_frozen_a: assert property (lock_r && boot_r == wdc_pkg::WDC_RUN |=> $stable(ctrl_r)) // R5
        else $error("control changed while frozen");
    guard_needed_a: assert property (wr_ctrl && !guard_open && !boot_load |=> $stable(ctrl_r)) // R18
        else $error("control written without unlock");
    busy_raise_a: assert property (xfer_start |=> busy) // R10
        else $error("pending flag not raised after control write");
    busy_drop_a: assert property (xfer_done |-> !busy ##1 act_r == $past(ctrl_r)) // R11
        else $error("transfer finished without applying control");
    boot_lock_a: assert property (boot_load && FUSE_CFG[3:0] != 4'h0 |=> lock_r && ctrl_r == $past(FUSE_CFG)) // R8
        else $error("boot load did not freeze configuration");
    early_kick_a: assert property (tick && kick_r && st_r == wdc_pkg::WDC_CLOSED && !DEBUG_MODE && !xfer_done && per_sel != 4'h0 |=> SYS_RESET_REQ) // R16
        else $error("kick in closed window did not reset");
    timeout_a: assert property (tick && st_r == wdc_pkg::WDC_OPEN && !kick_r && cnt_inc >= lim && !DEBUG_MODE && !xfer_done && per_sel != 4'h0 |=> SYS_RESET_REQ) // R15
        else $error("timeout did not reset");
    status_zero_a: assert property (disable iff (1'b0) SYS_RST |=> !lock_r && !busy) // R13
        else $error("status not zero after reset");
    irq_track_a: assert property (IRQ == |(evt_r & mask_r))
        else $error("interrupt does not follow masked events");

    // read port
    rd_idle_a: assert property (
        !bus.rd |=> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    rd_ctrl_a: assert property ( // R1
        bus.rd && bus.addr == wdc_pkg::CTRL_OFS |=> RDATA == $past(ctrl_r))
        else $error("control readback wrong");
    rd_stat_a: assert property ( // R10
        bus.rd && bus.addr == wdc_pkg::STAT_OFS |=> RDATA == {$past(lock_r), 6'h00, $past(busy)})
        else $error("status readback wrong");

    // freeze bit and pending flag
    stat_guard_a: assert property ( // R9
        wr_stat && !guard_open && !boot_load |=> $stable(lock_r))
        else $error("freeze bit written without unlock");
    lock_set_a: assert property ( // R6
        wr_stat && guard_open && bus.wdata[wdc_pkg::LOCK_BIT] && !boot_load |=> lock_r)
        else $error("freeze bit not set by guarded write");
    busy_guard_a: assert property ( // R12
        wr_stat && !busy |=> !busy)
        else $error("status write raised the pending flag");

    // durations
    open_len_a: assert property ( // R4
        st_r != wdc_pkg::WDC_CLOSED && per_sel == 4'h1 |-> lim == 14'h0008)
        else $error("open or normal length wrong");
    closed_len_a: assert property ( // R2
        st_r == wdc_pkg::WDC_CLOSED && win_sel == 4'h1 |-> lim == 14'h0008)
        else $error("closed length wrong");
    clamp_a: assert property ( // R19
        st_r != wdc_pkg::WDC_CLOSED && per_sel > wdc_pkg::SEL_MAX |-> lim == 14'h2000)
        else $error("reserved code not clamped to longest");

    // counter pacing and modes
    off_idle_a: assert property ( // R3
        per_sel == wdc_pkg::SEL_OFF |=> st_r == wdc_pkg::WDC_OFF && !SYS_RESET_REQ)
        else $error("disabled watchdog still running");
    tick_only_a: assert property ( // R17
        !tick && !xfer_done && !DEBUG_MODE && st_r != wdc_pkg::WDC_OFF
        && per_sel != wdc_pkg::SEL_OFF |=> $stable(cnt_r))
        else $error("counter moved without a slow tick");
    rst_on_tick_a: assert property ( // R17
        SYS_RESET_REQ |-> $past(tick))
        else $error("reset request not paced by a slow tick");
    closed_end_a: assert property ( // R16
        tick && st_r == wdc_pkg::WDC_CLOSED && !kick_r && cnt_inc >= lim && !DEBUG_MODE
        && !xfer_done && per_sel != 4'h0 |=> st_r == wdc_pkg::WDC_OPEN && !SYS_RESET_REQ)
        else $error("closed period did not hand over to open");
    debug_hold_a: assert property ( // R15
        DEBUG_MODE && per_sel != wdc_pkg::SEL_OFF |=> cnt_r == 14'h0 && !SYS_RESET_REQ)
        else $error("counter not held in debug mode");

    early_kick_c: cover property (early_ev);
    window_c: cover property (st_r == wdc_pkg::WDC_CLOSED);
    timeout_c: cover property (tmo_ev);
    sync_done_c: cover property (xfer_start ##[1:300] !busy);
    lock_set_c: cover property (!lock_r ##1 lock_r);
endmodule
`default_nettype wire

// file: logic/wdc_xfer.sv
`timescale 1ns/1ns
`default_nettype none
module wdc_xfer #(
    parameter int TICKS = wdc_pkg::SYNC_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic tick,
    output logic busy,
    output logic done
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic busy_nxt;
    logic done_nxt;

    // transfer into the tick domain completes after TICKS slow ticks
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy;
        done_nxt = 1'b0;
        if (start && !busy) begin
            busy_nxt = 1'b1;
            cnt_nxt = 4'h0;
        end else if (busy && tick) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(TICKS - 1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy <= busy_nxt;
            done <= done_nxt;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_watchdog_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module tb_watchdog_control_regs;
    localparam int TDIV = 4;
    logic REF_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic [7:0] RDATA;
    logic [7:0] FUSE_CFG = 8'h30;
    logic FUSE_DONE = 1'b0;
    logic GUARD_UNLOCK = 1'b0;
    logic DEBUG_MODE = 1'b0;
    logic KICK = 1'b0;
    logic SYS_RESET_REQ;
    logic IRQ;
    int n_mismatch = 0;
    int checks = 0;
    int n_rst = 0;
    int cnt;
    int n0;
    logic [7:0] v;

    wdc_top #(.TICK_DIV(TDIV)) DUT (
        .REF_CLK(REF_CLK),
        .SYS_RST(SYS_RST),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR_EN(WR_EN),
        .RD_EN(RD_EN),
        .RDATA(RDATA),
        .FUSE_CFG(FUSE_CFG),
        .FUSE_DONE(FUSE_DONE),
        .GUARD_UNLOCK(GUARD_UNLOCK),
        .DEBUG_MODE(DEBUG_MODE),
        .KICK(KICK),
        .SYS_RESET_REQ(SYS_RESET_REQ),
        .IRQ(IRQ)
    );

    always #5 REF_CLK = ~REF_CLK;

    always @(posedge REF_CLK) begin
        if (SYS_RESET_REQ === 1'b1) n_rst++;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge REF_CLK);
        WR_EN <= 1'b0;
    endtask

    // unlock pulse, then the write in the first cycle of the open window
    task automatic gwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        GUARD_UNLOCK <= 1'b1;
        @(posedge REF_CLK);
        GUARD_UNLOCK <= 1'b0;
        ADDR <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge REF_CLK);
        WR_EN <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge REF_CLK);
        RD_EN <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, exp, d)
    endtask

    task automatic kick();
        @(posedge REF_CLK);
        KICK <= 1'b1;
        @(posedge REF_CLK);
        KICK <= 1'b0;
    endtask

    task automatic do_reset(input logic [7:0] fuse);
        @(posedge REF_CLK);
        SYS_RST <= 1'b1;
        FUSE_DONE <= 1'b0;
        FUSE_CFG <= fuse;
        repeat (12) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        close_out();
    end

    initial begin
        do_reset(8'h30);
        rchk(wdc_pkg::STAT_OFS, 8'h00, "status reset");
        @(posedge REF_CLK);
        FUSE_DONE <= 1'b1;
        rchk(wdc_pkg::CTRL_OFS, 8'h30, "control from fuse");
        rchk(wdc_pkg::STAT_OFS, 8'h00, "no freeze, timeout off");
        rchk(8'h05, 8'h00, "unmapped read");
        wr(wdc_pkg::CTRL_OFS, 8'h5a);
        rchk(wdc_pkg::CTRL_OFS, 8'h30, "unguarded control write");
        wr(wdc_pkg::MASK_OFS, 8'h04);
        rchk(wdc_pkg::MASK_OFS, 8'h04, "mask readback");
        // window code 5, timeout off: fields land in their own nibbles
        gwr(wdc_pkg::CTRL_OFS, 8'h50);
        rchk(wdc_pkg::STAT_OFS, 8'h01, "pending after write");
        repeat (30) @(posedge REF_CLK);
        rchk(wdc_pkg::STAT_OFS, 8'h00, "pending cleared");
        rchk(wdc_pkg::CTRL_OFS, 8'h50, "control fields");
        `CHK("irq on transfer done", 1'b1, IRQ)
        rchk(wdc_pkg::EVT_OFS, 8'h04, "event transfer done");
        repeat (2) @(posedge REF_CLK);
        #1;
        `CHK("irq after read clear", 1'b0, IRQ)
        rchk(wdc_pkg::EVT_OFS, 8'h00, "event cleared");
        // timeout code 1 in normal mode: 8 ticks after the transfer
        gwr(wdc_pkg::CTRL_OFS, 8'h01);
        cnt = 0;
        while (SYS_RESET_REQ !== 1'b1 && cnt < 100) begin
            @(posedge REF_CLK);
            #1;
            cnt++;
        end
        `CHK("timeout span", 1'b1, (cnt >= 32 && cnt <= 48))
        rchk(wdc_pkg::EVT_OFS, 8'h05, "timeout event");
        n0 = n_rst;
        repeat (8) begin
            kick();
            repeat (14) @(posedge REF_CLK);
        end
        `CHK("kicked, no reset", n0, n_rst)
        // window 1, open 1: kick opens closed period, second kick is early
        gwr(wdc_pkg::CTRL_OFS, 8'h11);
        repeat (16) @(posedge REF_CLK);
        kick();
        repeat (8) @(posedge REF_CLK);
        n0 = n_rst;
        kick();
        repeat (12) @(posedge REF_CLK);
        `CHK("early kick reset", n0 + 1, n_rst)
        rd(wdc_pkg::EVT_OFS, v);
        `CHK("early kick event", 8'h02, v & 8'h02)
        wr(wdc_pkg::STAT_OFS, 8'h80);
        rchk(wdc_pkg::STAT_OFS, 8'h00, "unguarded freeze");
        gwr(wdc_pkg::STAT_OFS, 8'h80);
        rchk(wdc_pkg::STAT_OFS, 8'h80, "freeze set");
        gwr(wdc_pkg::CTRL_OFS, 8'h22);
        rchk(wdc_pkg::CTRL_OFS, 8'h11, "frozen control");
        rchk(wdc_pkg::STAT_OFS, 8'h80, "no pending when frozen");
        gwr(wdc_pkg::STAT_OFS, 8'h00);
        rchk(wdc_pkg::STAT_OFS, 8'h80, "clear outside debug");
        @(posedge REF_CLK);
        DEBUG_MODE <= 1'b1;
        gwr(wdc_pkg::STAT_OFS, 8'h00);
        rchk(wdc_pkg::STAT_OFS, 8'h00, "clear in debug");
        gwr(wdc_pkg::CTRL_OFS, 8'h22);
        repeat (30) @(posedge REF_CLK);
        rchk(wdc_pkg::CTRL_OFS, 8'h22, "unfrozen control");
        gwr(wdc_pkg::CTRL_OFS, 8'h0c);
        repeat (30) @(posedge REF_CLK);
        rchk(wdc_pkg::CTRL_OFS, 8'h0c, "reserved code kept");
        @(posedge REF_CLK);
        DEBUG_MODE <= 1'b0;
        // fuse with timeout code set freezes at boot
        do_reset(8'h01);
        rchk(wdc_pkg::STAT_OFS, 8'h00, "status second reset");
        @(posedge REF_CLK);
        FUSE_DONE <= 1'b1;
        rchk(wdc_pkg::STAT_OFS, 8'h80, "boot freeze");
        rchk(wdc_pkg::CTRL_OFS, 8'h01, "control from fuse");
        close_out();
    end
endmodule
`default_nettype wire
